// >>> verilog/tlm_params.svh
`ifndef TLM_PARAMS_SVH
`define TLM_PARAMS_SVH
// register word offsets (byte addresses)
`define TLM_OFS_CTRL 8'h00
`define TLM_OFS_MODE_A 8'h04
`define TLM_OFS_MODE_B 8'h08
`define TLM_OFS_LOAD_A 8'h10
`define TLM_OFS_LOAD_A_HI 8'h14
`define TLM_OFS_LOAD_B 8'h18
`define TLM_OFS_MATCH_A 8'h20
`define TLM_OFS_MATCH_A_HI 8'h24
`define TLM_OFS_MATCH_B 8'h28
`define TLM_OFS_PRESC_A 8'h30
`define TLM_OFS_PRESC_B 8'h34
`define TLM_OFS_PMATCH_A 8'h38
`define TLM_OFS_PMATCH_B 8'h3c
`define TLM_OFS_VALUE_A 8'h40
`define TLM_OFS_VALUE_A_HI 8'h44
`define TLM_OFS_VALUE_B 8'h48
`define TLM_OFS_RIS 8'h50
`define TLM_OFS_MIS 8'h54
`define TLM_OFS_IMR 8'h58
// control fields
`define TLM_CTRL_EN_A 0
`define TLM_CTRL_EN_B 1
`define TLM_CTRL_SPLIT 2
`define TLM_MODE_LSB 0
`define TLM_MODE_UP 2
// interrupt bit positions
`define TLM_INT_W 11
`define TLM_INT_TO_A 0
`define TLM_INT_MT_A 1
`define TLM_INT_EV_A 2
`define TLM_INT_RTC 3
`define TLM_INT_TO_B 8
`define TLM_INT_MT_B 9
`define TLM_INT_EV_B 10
// reset values
`define TLM_RST_CTRL 3'h0
`define TLM_RST_MODE 3'h0
`define TLM_RST_WORD 32'h0
`define TLM_RST_IMR 11'h000
`endif

// >>> verilog/tlm_pkg.sv
`default_nettype none
package tlm_pkg;
  // gray coded along oneshot, periodic, count, pwm
  typedef enum logic [1:0] {
    TLM_ONESHOT = 2'h0,
    TLM_PERIODIC = 2'h1,
    TLM_CAPCOUNT = 2'h3,
    TLM_PWM = 2'h2
  } tlm_mode_t;
endpackage : tlm_pkg
`default_nettype wire

// >>> verilog/tlm_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlm_params.svh"
module tlm_irq (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // events and software side
  input wire logic [`TLM_INT_W-1:0] evt,
  input wire logic [`TLM_INT_W-1:0] clr,
  input wire logic [`TLM_INT_W-1:0] mask,
  output logic [`TLM_INT_W-1:0] ris,
  output logic [`TLM_INT_W-1:0] mis,
  output logic irq
);
  import tlm_pkg::*;
  logic [`TLM_INT_W-1:0] ris_r, ris_nxt;
  logic irq_r, irq_nxt;

  always_comb begin
    // set wins over a clear in the same cycle
    ris_nxt = (ris_r & ~clr) | evt;
    irq_nxt = |(ris_nxt & mask);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ris_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ris_r <= ris_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign ris = ris_r;
  assign mis = ris_r & mask;
  assign irq = irq_r;
endmodule // tlm_irq
`default_nettype wire

// >>> verilog/tlm_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module tlm_cnt #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic en,
  input wire tlm_pkg::tlm_mode_t mode,
  input wire logic up,
  input wire logic tick,
  input wire logic ld,
  input wire logic [W-1:0] load,
  input wire logic [W-1:0] match,
  // state and events
  output logic [W-1:0] value,
  output logic timeout,
  output logic match_hit,
  output logic pwm
);
  import tlm_pkg::*;
  logic [W-1:0] cnt_r, cnt_nxt, start;
  logic done_r, done_nxt, to_r, to_nxt, mh_r, mh_nxt;
  logic pwm_r, pwm_nxt, step, end_hit;

  if (W < 1) begin : g_bad_w
    $error("tlm_cnt: W must be at least 1");
  end

  always_comb begin
    start = up ? '0 : load;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    to_nxt = 1'b0;
    mh_nxt = 1'b0;
    end_hit = up ? (cnt_r == load) : (cnt_r == '0);
    // edge counting advances only on a qualified edge
    step = (mode == TLM_CAPCOUNT) ? tick : 1'b1;
    if (!en) begin
      cnt_nxt = start;
      done_nxt = 1'b0;
    end else if (ld) begin
      cnt_nxt = start;
      done_nxt = 1'b0;
    end else if (step && !done_r) begin
      if (end_hit) begin
        to_nxt = 1'b1;
        cnt_nxt = start;
        if (mode == TLM_ONESHOT) begin
          cnt_nxt = cnt_r;
          done_nxt = 1'b1;
        end
      end else begin
        cnt_nxt = up ? cnt_r + 1'b1 : cnt_r - 1'b1;
      end
      mh_nxt = (cnt_nxt == match) && (mode != TLM_PWM);
    end
    pwm_nxt = en && (mode == TLM_PWM) && (cnt_nxt > match);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      to_r <= 1'b0;
      mh_r <= 1'b0;
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      to_r <= to_nxt;
      mh_r <= mh_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign value = cnt_r;
  assign timeout = to_r;
  assign match_hit = mh_r;
  assign pwm = pwm_r;
endmodule // tlm_cnt
`default_nettype wire

// >>> verilog/tlm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlm_params.svh"
module tlm_top #(
  parameter int HALF_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins
  input wire logic cap_a,
  input wire logic cap_b,
  input wire logic rtc_evt,
  output logic pwm_a,
  output logic pwm_b,
  output logic irq
);
  import tlm_pkg::*;
  localparam int FW = 2 * HALF_W;
  localparam int PS_W = HALF_W / 2;
  localparam int EW = HALF_W + PS_W;

  if (HALF_W != 16 && HALF_W != 32) begin : g_bad_w
    $error("tlm_top: HALF_W must be 16 or 32");
  end

  logic [2:0] ctrl_r, ctrl_nxt;
  logic [2:0] mode_a_r, mode_a_nxt, mode_b_r, mode_b_nxt;
  logic [FW-1:0] load_a_r, load_a_nxt, match_a_r, match_a_nxt;
  logic [HALF_W-1:0] load_b_r, load_b_nxt, match_b_r, match_b_nxt;
  logic [PS_W-1:0] presc_a_r, presc_a_nxt, presc_b_r, presc_b_nxt;
  logic [PS_W-1:0] pmat_a_r, pmat_a_nxt, pmat_b_r, pmat_b_nxt;
  logic [31:0] stage_r, stage_nxt, snap_r, snap_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [`TLM_INT_W-1:0] imr_r, imr_nxt;
  logic ld_a_r, ld_a_nxt, ld_b_r, ld_b_nxt;
  logic [63:0] wide_w;
  logic [63:0] va_64, la_64, ma_64;

  // pin synchronisers, three stages each
  localparam int NS = 3;
  logic [NS-1:0] pin_in;
  logic [NS-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt, edge_r, edge_nxt;
  assign pin_in = {rtc_evt, cap_b, cap_a};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_comb begin
        // level accepted once stages two and three agree
        lvl_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : lvl_r[gi];
        edge_nxt[gi] = lvl_nxt[gi] & ~lvl_r[gi];
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
          edge_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          lvl_r[gi] <= lvl_nxt[gi];
          edge_r[gi] <= edge_nxt[gi];
        end
      end
    end
  endgenerate

  // effective counter operands
  logic split;
  tlm_mode_t md_a, md_b;
  logic up_a, up_b, lsb_a, lsb_b;
  logic [FW-1:0] eff_load_a, eff_match_a;
  logic [EW-1:0] eff_load_b, eff_match_b;
  logic [FW-1:0] val_a;
  logic [EW-1:0] val_b;
  logic to_a, to_b, mh_a, mh_b;

  assign split = ctrl_r[`TLM_CTRL_SPLIT];
  assign md_a = tlm_mode_t'(mode_a_r[1:0]);
  assign md_b = tlm_mode_t'(mode_b_r[1:0]);
  assign up_a = mode_a_r[`TLM_MODE_UP];
  assign up_b = mode_b_r[`TLM_MODE_UP];
  // low bits only for down periodic/one-shot
  assign lsb_a = !up_a && (md_a == TLM_ONESHOT || md_a == TLM_PERIODIC);
  assign lsb_b = !up_b && (md_b == TLM_ONESHOT || md_b == TLM_PERIODIC);

  always_comb begin
    eff_load_a = load_a_r;
    eff_match_a = match_a_r;
    if (split) begin
      eff_load_a = FW'(lsb_a ? {load_a_r[HALF_W-1:0], presc_a_r}
                              : {presc_a_r, load_a_r[HALF_W-1:0]});
      eff_match_a = FW'(lsb_a ? {match_a_r[HALF_W-1:0], pmat_a_r}
                               : {pmat_a_r, match_a_r[HALF_W-1:0]});
    end
    eff_load_b = lsb_b ? {load_b_r, presc_b_r} : {presc_b_r, load_b_r};
    eff_match_b = lsb_b ? {match_b_r, pmat_b_r} : {pmat_b_r, match_b_r};
  end

  tlm_cnt #(.W(FW)) u_cnt_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(ctrl_r[`TLM_CTRL_EN_A]),
    .mode(md_a),
    .up(up_a),
    .tick(edge_r[0]),
    .ld(ld_a_r),
    .load(eff_load_a),
    .match(eff_match_a),
    .value(val_a),
    .timeout(to_a),
    .match_hit(mh_a),
    .pwm(pwm_a)
  );

  // second half idle in full width
  tlm_cnt #(.W(EW)) u_cnt_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(ctrl_r[`TLM_CTRL_EN_B] && split),
    .mode(md_b),
    .up(up_b),
    .tick(edge_r[1]),
    .ld(ld_b_r),
    .load(eff_load_b),
    .match(eff_match_b),
    .value(val_b),
    .timeout(to_b),
    .match_hit(mh_b),
    .pwm(pwm_b)
  );

  logic [`TLM_INT_W-1:0] evt, clr, ris, mis;
  always_comb begin
    evt = '0;
    evt[`TLM_INT_TO_A] = to_a;
    evt[`TLM_INT_MT_A] = mh_a;
    evt[`TLM_INT_EV_A] = edge_r[0] && md_a == TLM_CAPCOUNT;
    evt[`TLM_INT_RTC] = edge_r[2];
    evt[`TLM_INT_TO_B] = to_b;
    evt[`TLM_INT_MT_B] = mh_b;
    evt[`TLM_INT_EV_B] = edge_r[1] && md_b == TLM_CAPCOUNT;
    clr = (wr && addr == `TLM_OFS_RIS) ? wdata[`TLM_INT_W-1:0] : '0;
  end

  tlm_irq u_irq (
    .ref_clk(ref_clk),
    .rst(rst),
    .evt(evt),
    .clr(clr),
    .mask(imr_r),
    .ris(ris),
    .mis(mis),
    .irq(irq)
  );

  // register writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    mode_a_nxt = mode_a_r;
    mode_b_nxt = mode_b_r;
    load_a_nxt = load_a_r;
    load_b_nxt = load_b_r;
    match_a_nxt = match_a_r;
    match_b_nxt = match_b_r;
    presc_a_nxt = presc_a_r;
    presc_b_nxt = presc_b_r;
    pmat_a_nxt = pmat_a_r;
    pmat_b_nxt = pmat_b_r;
    imr_nxt = imr_r;
    stage_nxt = stage_r;
    ld_a_nxt = 1'b0;
    ld_b_nxt = 1'b0;
    // high word staged, low write commits whole value
    wide_w = {stage_r, wdata};
    if (wr) begin
      unique case (addr)
        `TLM_OFS_CTRL: ctrl_nxt = wdata[2:0];
        `TLM_OFS_MODE_A: mode_a_nxt = wdata[2:0];
        `TLM_OFS_MODE_B: mode_b_nxt = wdata[2:0];
        `TLM_OFS_LOAD_A: begin
          load_a_nxt = wide_w[FW-1:0];
          ld_a_nxt = 1'b1;
        end
        `TLM_OFS_LOAD_A_HI: stage_nxt = wdata;
        `TLM_OFS_LOAD_B: begin
          load_b_nxt = wdata[HALF_W-1:0];
          ld_b_nxt = 1'b1;
        end
        `TLM_OFS_MATCH_A: match_a_nxt = wide_w[FW-1:0];
        `TLM_OFS_MATCH_A_HI: stage_nxt = wdata;
        `TLM_OFS_MATCH_B: match_b_nxt = wdata[HALF_W-1:0];
        `TLM_OFS_PRESC_A: presc_a_nxt = wdata[PS_W-1:0];
        `TLM_OFS_PRESC_B: presc_b_nxt = wdata[PS_W-1:0];
        `TLM_OFS_PMATCH_A: pmat_a_nxt = wdata[PS_W-1:0];
        `TLM_OFS_PMATCH_B: pmat_b_nxt = wdata[PS_W-1:0];
        `TLM_OFS_IMR: imr_nxt = wdata[`TLM_INT_W-1:0];
        default: ;
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe
  always_comb begin
    va_64 = 64'(val_a);
    la_64 = 64'(load_a_r);
    ma_64 = 64'(match_a_r);
    rdata_nxt = '0;
    snap_nxt = snap_r;
    if (rd) begin
      unique case (addr)
        `TLM_OFS_CTRL: rdata_nxt = 32'(ctrl_r);
        `TLM_OFS_MODE_A: rdata_nxt = 32'(mode_a_r);
        `TLM_OFS_MODE_B: rdata_nxt = 32'(mode_b_r);
        `TLM_OFS_LOAD_A: begin
          rdata_nxt = la_64[31:0];
          snap_nxt = la_64[63:32];
        end
        `TLM_OFS_LOAD_B: rdata_nxt = 32'(load_b_r);
        `TLM_OFS_MATCH_A: begin
          rdata_nxt = ma_64[31:0];
          snap_nxt = ma_64[63:32];
        end
        `TLM_OFS_MATCH_B: rdata_nxt = 32'(match_b_r);
        `TLM_OFS_PRESC_A: rdata_nxt = 32'(presc_a_r);
        `TLM_OFS_PRESC_B: rdata_nxt = 32'(presc_b_r);
        `TLM_OFS_PMATCH_A: rdata_nxt = 32'(pmat_a_r);
        `TLM_OFS_PMATCH_B: rdata_nxt = 32'(pmat_b_r);
        `TLM_OFS_VALUE_A: begin
          rdata_nxt = va_64[31:0];
          snap_nxt = va_64[63:32];
        end
        // high halves come from the snapshot of the low read
        `TLM_OFS_LOAD_A_HI,
        `TLM_OFS_MATCH_A_HI,
        `TLM_OFS_VALUE_A_HI: rdata_nxt = snap_r;
        `TLM_OFS_VALUE_B: rdata_nxt = 32'(val_b);
        `TLM_OFS_RIS: rdata_nxt = 32'(ris);
        `TLM_OFS_MIS: rdata_nxt = 32'(mis);
        `TLM_OFS_IMR: rdata_nxt = 32'(imr_r);
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= `TLM_RST_CTRL;
      mode_a_r <= `TLM_RST_MODE;
      mode_b_r <= `TLM_RST_MODE;
      load_a_r <= '0;
      load_b_r <= '0;
      match_a_r <= '0;
      match_b_r <= '0;
      presc_a_r <= '0;
      presc_b_r <= '0;
      pmat_a_r <= '0;
      pmat_b_r <= '0;
      imr_r <= `TLM_RST_IMR;
      stage_r <= `TLM_RST_WORD;
      snap_r <= `TLM_RST_WORD;
      rdata_r <= `TLM_RST_WORD;
      ld_a_r <= 1'b0;
      ld_b_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_a_r <= mode_a_nxt;
      mode_b_r <= mode_b_nxt;
      load_a_r <= load_a_nxt;
      load_b_r <= load_b_nxt;
      match_a_r <= match_a_nxt;
      match_b_r <= match_b_nxt;
      presc_a_r <= presc_a_nxt;
      presc_b_r <= presc_b_nxt;
      pmat_a_r <= pmat_a_nxt;
      pmat_b_r <= pmat_b_nxt;
      imr_r <= imr_nxt;
      stage_r <= stage_nxt;
      snap_r <= snap_nxt;
      rdata_r <= rdata_nxt;
      ld_a_r <= ld_a_nxt;
      ld_b_r <= ld_b_nxt;
    end
  end

  assign rdata = rdata_r;
endmodule // tlm_top
`default_nettype wire

// >>> dv/tlm_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlm_params.svh"
module tlm_top_sva #(
  parameter int HALF_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // pins
  input wire logic cap_a,
  input wire logic cap_b,
  input wire logic rtc_evt,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic irq
);
  import tlm_pkg::*;
  // shadows of what software last wrote
  logic [`TLM_INT_W-1:0] mask_r;
  logic [1:0] mode_a_r;
  logic [1:0] mode_b_r;
  logic [HALF_W-1:0] load_b_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= '0;
      mode_a_r <= 2'h0;
      mode_b_r <= 2'h0;
      load_b_r <= '0;
    end else if (wr) begin
      if (addr == `TLM_OFS_IMR) mask_r <= wdata[`TLM_INT_W-1:0];
      if (addr == `TLM_OFS_MODE_A) mode_a_r <= wdata[1:0];
      if (addr == `TLM_OFS_MODE_B) mode_b_r <= wdata[1:0];
      if (addr == `TLM_OFS_LOAD_B) load_b_r <= wdata[HALF_W-1:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_rd: assert property (rd && addr == 8'hfc |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_load_back: assert property (
    rd && addr == `TLM_OFS_LOAD_B |=> rdata == 32'(load_b_r))
    else $error("load read back differs from written value");
  a_presc_width: assert property (
    rd && addr == `TLM_OFS_PRESC_A |=> (rdata >> (HALF_W / 2)) == 32'h0)
    else $error("prescaler wider than allowed");
  a_pmatch_width: assert property (
    rd && addr == `TLM_OFS_PMATCH_A |=> (rdata >> (HALF_W / 2)) == 32'h0)
    else $error("prescale match wider than allowed");
  a_irq_masked: assert property (
    mask_r == '0 && $past(mask_r) == '0 |-> !irq)
    else $error("interrupt high with all sources disabled");
  a_mis_masked: assert property (
    rd && addr == `TLM_OFS_MIS && mask_r == '0 && $past(mask_r) == '0
    |=> rdata == 32'h0)
    else $error("masked status not zero under empty mask");
  a_pwm_a_off: assert property (
    mode_a_r != TLM_PWM && $past(mode_a_r) != TLM_PWM |-> !pwm_a)
    else $error("pwm a output high outside pwm mode");
  a_pwm_b_off: assert property (
    mode_b_r != TLM_PWM && $past(mode_b_r) != TLM_PWM |-> !pwm_b)
    else $error("pwm b output high outside pwm mode");
  a_rtc_irq: assert property (
    $rose(rtc_evt) && mask_r[`TLM_INT_RTC] |-> ##[1:12] irq)
    else $error("enabled rtc edge raised no interrupt");
endmodule // tlm_top_sva
bind tlm_top tlm_top_sva #(.HALF_W(HALF_W)) tlm_top_sva_i (.ref_clk, .rst,
  .addr, .wdata, .wr, .rd, .rdata, .cap_a, .cap_b, .rtc_evt, .pwm_a,
  .pwm_b, .irq);
`default_nettype wire

// >>> dv/tlm_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlm_params.svh"
module tlm_top_bench;
  import tlm_pkg::*;
  logic ref_clk, rst, wr, rd, cap_a, cap_b, rtc_evt, irq, pwm_a, pwm_b;
  logic [7:0] addr, b;
  logic [31:0] wdata, rdata, rdata_w, got, got_w;
  logic [7:0] offs [9];
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  tlm_top #(.HALF_W(16)) tlm_top_i (.ref_clk, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .cap_a, .cap_b, .rtc_evt, .pwm_a, .pwm_b, .irq);
  // wide variant shares the bus; only its read data is judged
  tlm_top #(.HALF_W(32)) tlm_top_wide_i (.ref_clk, .rst, .addr, .wdata,
    .wr, .rd, .rdata(rdata_w), .cap_a, .cap_b, .rtc_evt, .pwm_a(),
    .pwm_b(), .irq());
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // answer taken at the edge after the strobe, before it is replaced
  task automatic rreg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    got = rdata;
    got_w = rdata_w;
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      cap_a <= 1'b1;
      cap_b <= 1'b1;
      repeat (6) @(posedge ref_clk);
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    cap_a = 1'b0;
    cap_b = 1'b0;
    rtc_evt = 1'b0;
    offs = '{`TLM_OFS_CTRL, `TLM_OFS_MODE_A, `TLM_OFS_LOAD_A,
      `TLM_OFS_MATCH_A, `TLM_OFS_PRESC_A, `TLM_OFS_VALUE_B, `TLM_OFS_RIS,
      `TLM_OFS_IMR, 8'hfc};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // reset state, unmapped word reads zero
    foreach (offs[i]) begin
      rreg(offs[i]);
      chk(got, 32'h0);
    end
    wreg(`TLM_OFS_PMATCH_A, 32'hffffffff);
    rreg(`TLM_OFS_PMATCH_A);
    chk(got, 32'h000000ff);
    chk(got_w, 32'h0000ffff);
    wreg(`TLM_OFS_PRESC_B, 32'hffffffff);
    rreg(`TLM_OFS_PRESC_B);
    chk(got, 32'h000000ff);
    chk(got_w, 32'h0000ffff);
    wreg(`TLM_OFS_PMATCH_A, 32'h0);
    wreg(`TLM_OFS_PRESC_B, 32'h0);
    // prescale low bits when down, high bits when up: both end fast
    wreg(`TLM_OFS_PRESC_A, 32'h3);
    wreg(`TLM_OFS_IMR, 32'h001);
    wreg(`TLM_OFS_CTRL, 32'h5);
    wait_irq(30);
    wreg(`TLM_OFS_MODE_B, 32'h5);
    wreg(`TLM_OFS_LOAD_B, 32'h3);
    wreg(`TLM_OFS_MATCH_B, 32'h7);
    wreg(`TLM_OFS_IMR, 32'h100);
    wreg(`TLM_OFS_CTRL, 32'h7);
    wait_irq(30);
    rreg(`TLM_OFS_LOAD_B);
    chk(got, 32'h3);
    wreg(`TLM_OFS_CTRL, 32'h0);
    rreg(`TLM_OFS_RIS);
    chk(got & 32'h103, 32'h103);
    wreg(`TLM_OFS_IMR, 32'h001);
    rreg(`TLM_OFS_MIS);
    chk(got, 32'h001);
    chk({31'h0, irq}, 32'h1);
    wreg(`TLM_OFS_IMR, 32'h0);
    rreg(`TLM_OFS_MIS);
    chk(got, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wreg(`TLM_OFS_RIS, 32'h7ff);
    rreg(`TLM_OFS_RIS);
    chk(got, 32'h0);
    // reload while running lands at once, not at interval end
    // prescaler still 3: ignored in full width, low bits when split down
    wreg(`TLM_OFS_MODE_A, 32'h1);
    wreg(`TLM_OFS_LOAD_A, 32'h100);
    rreg(`TLM_OFS_VALUE_A);
    chk(got, 32'h100);
    wreg(`TLM_OFS_CTRL, 32'h5);
    wreg(`TLM_OFS_LOAD_A, 32'h2);
    repeat (2) @(posedge ref_clk);
    rreg(`TLM_OFS_VALUE_A);
    chk({31'h0, got <= 32'd515 && got > 32'd503}, 32'h1);
    rreg(`TLM_OFS_LOAD_A);
    chk(got, 32'h2);
    // edge count meets match on the third edge
    wreg(`TLM_OFS_CTRL, 32'h0);
    wreg(`TLM_OFS_MODE_A, 32'h7);
    wreg(`TLM_OFS_LOAD_A, 32'hff);
    wreg(`TLM_OFS_MATCH_A, 32'h3);
    wreg(`TLM_OFS_PMATCH_A, 32'h1);
    wreg(`TLM_OFS_RIS, 32'h7ff);
    wreg(`TLM_OFS_CTRL, 32'h5);
    // prescale match widens match, so the third edge misses it
    pulse(3);
    rreg(`TLM_OFS_RIS);
    chk(got & 32'h6, 32'h4);
    wreg(`TLM_OFS_PMATCH_A, 32'h0);
    wreg(`TLM_OFS_LOAD_A, 32'hff);
    pulse(2);
    rreg(`TLM_OFS_RIS);
    chk(got & 32'h6, 32'h4);
    pulse(1);
    rreg(`TLM_OFS_RIS);
    chk(got & 32'h6, 32'h6);
    // pwm duty from match, period of eleven counts
    wreg(`TLM_OFS_MODE_B, 32'h2);
    wreg(`TLM_OFS_LOAD_B, 32'ha);
    wreg(`TLM_OFS_MATCH_B, 32'h5);
    wreg(`TLM_OFS_CTRL, 32'h6);
    n = 0;
    repeat (44) begin
      @(posedge ref_clk);
      n += int'(pwm_b);
    end
    chk({31'h0, n >= 18 && n <= 26}, 32'h1);
    chk({31'h0, pwm_a}, 32'h0);
    // half b edge count: match on the first edge, event on each
    wreg(`TLM_OFS_MODE_B, 32'h3);
    wreg(`TLM_OFS_LOAD_B, 32'h2);
    wreg(`TLM_OFS_MATCH_B, 32'h1);
    wreg(`TLM_OFS_RIS, 32'h7ff);
    pulse(1);
    rreg(`TLM_OFS_RIS);
    chk(got & 32'h600, 32'h600);
    wreg(`TLM_OFS_IMR, 32'h8);
    rtc_evt <= 1'b1;
    wait_irq(12);
    wreg(`TLM_OFS_RIS, 32'h8);
    rreg(`TLM_OFS_RIS);
    chk(got & 32'h8, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // full width: wide values go in and out whole, first half only
    wreg(`TLM_OFS_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      b = k ? `TLM_OFS_MATCH_A : `TLM_OFS_LOAD_A;
      wreg(b + 8'h4, 32'hc3a50f00 + k);
      wreg(b, 32'h5a3c00f0 + k);
      rreg(b);
      chk(got_w, 32'h5a3c00f0 + k);
      rreg(b + 8'h4);
      chk(got_w, 32'hc3a50f00 + k);
      chk(got, 32'h0);
    end
    close_out();
  end
  // span well above the whole sequence
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule // tlm_top_bench
`default_nettype wire
